//--- adc_trig_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_trig_checker
   import adc_trig_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire core_req_t coreReq,
   input wire core_rsp_t coreRsp,
   input wire result_fwd_t resultFwd,
   input wire logic [3:0] cmpEvent,
   input wire logic [3:0] fltDone
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic convBusy;
   // ==========================================
   // conversion in flight
   always_ff @(posedge core_clk) begin
      if (!rst_n) convBusy <= 1'b0;
      else if (coreReq.start) convBusy <= 1'b1;
      else if (coreRsp.done) convBusy <= 1'b0;
   end
   // ==========================================
   // core and result timing
   a_start_idle: assert property (
      coreReq.start |-> !convBusy) else $error("start while busy");
   a_start_pulse: assert property (
      coreReq.start |=> !coreReq.start) else $error("start not a pulse");
   a_start_chan: assert property (
      coreReq.start |-> coreReq.channel < 5'd20) else $error("bad channel");
   a_done_fwd: assert property (
      coreRsp.done |=> resultFwd.valid) else $error("result not forwarded");
   a_fwd_cause: assert property (
      resultFwd.valid |-> $past(coreRsp.done)) else $error("stray result");
   a_fwd_chan: assert property (
      resultFwd.valid |-> resultFwd.channel == coreReq.channel) else $error("wrong channel");
   a_fmt_unsigned: assert property (
      resultFwd.valid && !coreReq.signedFmt |-> resultFwd.data == 16'($past(coreRsp.data)))
      else $error("unsigned format");
   a_fmt_signed: assert property (
      resultFwd.valid && coreReq.signedFmt |->
      resultFwd.data == 16'($past(coreRsp.data)) - (16'h1 << (5 + 2 * coreReq.resolution)))
      else $error("signed format");
   a_cmp_result: assert property (
      |cmpEvent |-> resultFwd.valid) else $error("compare without result");
   a_flt_result: assert property (
      |fltDone |-> resultFwd.valid) else $error("filter without result");
endmodule
bind adc_trigger_and_result_control adc_trig_checker chk (.core_clk(core_clk), .rst_n(rst_n),
   .coreReq(coreReq), .coreRsp(coreRsp), .resultFwd(resultFwd), .cmpEvent(cmpEvent), .fltDone(fltDone));
`default_nettype wire

//--- adc_trig_pkg.sv
// What this block does
// RULE1 - each input picks its own trigger
// RULE2 - five-bit selector, zero means no trigger
// RULE3 - 1 common, 2 level software, 3 reserved
// RULE4 - 31 selects synchronised external trigger pin
// RULE5 - 30 generator, 29/28 logic cells, 27/26 reserved
// RULE6 - 25/24 primary generators 3 and 1
// RULE7 - 23..20 capture units 4..1, 19..16 reserved
// RULE8 - 15..12 secondary generators 8..5 trigger one
// RULE9 - 11..4 generators 4..1 trigger pairs; code 5 takes generator 2 trigger two, not generator 1
// RULE10 - twenty inputs, each own 16-bit result
// RULE11 - per-input signed or unsigned result format
// RULE12 - store result, forward to comparators, filters
// RULE13 - core gets format, mode and input number
// RULE14 - one shared core serialises all conversions
// RULE15 - four comparators, each assignable to input
// RULE16 - four oversampling filters, each one input
// RULE17 - software resolution, at most twelve bits
// RULE18 - reserved codes never start a conversion
// RULE19 - events queue requests, serviced one at once
package adc_trig_pkg;
   localparam int NUM_CH = 20;
   localparam int NUM_CMP = 4;
   localparam int NUM_FLT = 4;
   localparam int SEL_W = 5;
   // ==========================================================
   // trigger source codes
   localparam logic [4:0] SRC_NONE = 5'h00;
   localparam logic [4:0] SRC_SW_COMMON = 5'h01;
   localparam logic [4:0] SRC_SW_LEVEL = 5'h02;
   localparam logic [4:0] SRC_SEC_PWM_LO = 5'h04;
   localparam logic [4:0] SRC_SEC_PWM_HI = 5'h0c;
   localparam logic [4:0] SRC_CCP_BASE = 5'h14;
   localparam logic [4:0] SRC_PRI_PWM1_T2 = 5'h18;
   localparam logic [4:0] SRC_PRI_PWM3_T2 = 5'h19;
   localparam logic [4:0] SRC_PRI_CELL = 5'h1c;
   localparam logic [4:0] SRC_SEC_CELL = 5'h1d;
   localparam logic [4:0] SRC_PRI_GEN = 5'h1e;
   localparam logic [4:0] SRC_EXT_PIN = 5'h1f;
   // ==========================================================
   // register byte offsets
   localparam logic [11:0] TRIG_SEL_BASE = 12'h000;
   localparam logic [11:0] CTRL_OFS = 12'h050;
   localparam logic [11:0] PEND_OFS = 12'h054;
   localparam logic [11:0] READY_OFS = 12'h058;
   localparam logic [11:0] CMP_BASE = 12'h060;
   localparam logic [11:0] FLT_CFG_BASE = 12'h070;
   localparam logic [11:0] FLT_RES_BASE = 12'h080;
   localparam logic [11:0] RESULT_BASE = 12'h100;
   // ==========================================================
   // field positions and reset values
   localparam int SEL_SIGNED_BIT = 8;
   localparam int CTRL_LEVEL_BIT = 2;
   localparam int CTRL_SWTRIG_BIT = 3;
   localparam int CFG_EN_BIT = 8;
   localparam int CFG_MODE_LSB = 9;
   localparam int CMP_THR_LSB = 16;
   localparam logic [1:0] RES_RESET = 2'h3;
   localparam logic [3:0] FLT_LAST = 4'hf;
   localparam int FLT_SHIFT = 2;
   localparam logic [1:0] CMP_BELOW = 2'h0;
   localparam logic [1:0] CMP_AT_ABOVE = 2'h1;
   localparam logic [1:0] CMP_EQUAL = 2'h2;
   // ==========================================================
   // types
   typedef enum logic [1:0] {CORE_IDLE = 2'b01, CORE_BUSY = 2'b10} core_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic start;
      logic [4:0] channel;
      logic [1:0] resolution;
      logic signedFmt;
   } core_req_t;
   typedef struct packed {
      logic done;
      logic [11:0] data;
   } core_rsp_t;
   typedef struct packed {
      logic valid;
      logic [4:0] channel;
      logic [15:0] data;
   } result_fwd_t;
endpackage

//--- adc_trigger_and_result_control.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_and_result_control
   import adc_trig_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extTrigPin,
   input wire logic priGenTrig,
   input wire logic secClcTrig,
   input wire logic priClcTrig,
   input wire logic priPwm3Trig2,
   input wire logic priPwm1Trig2,
   input wire logic [3:0] ccpEvent,
   input wire logic [7:0] secPwmTrig1,
   input wire logic [3:0] secPwmTrig2,
   output core_req_t coreReq,
   input wire core_rsp_t coreRsp,
   output result_fwd_t resultFwd,
   output logic [3:0] cmpEvent,
   output logic [3:0] fltDone
);
   // ==========================================================
   // state
   typedef struct packed {
      core_state_t coreState;
      logic [NUM_CH-1:0][4:0] trigSel;
      logic [NUM_CH-1:0] signedFmt;
      logic [1:0] resolution;
      logic levelSw;
      logic swPulse;
      logic [NUM_CH-1:0] pending;
      logic [NUM_CH-1:0] ready;
      logic [4:0] curCh;
      logic [NUM_CH-1:0][15:0] result;
      logic [NUM_CMP-1:0][31:0] cmpCfg;
      logic [NUM_FLT-1:0][8:0] fltCfg;
      logic [NUM_FLT-1:0][15:0] fltSum;
      logic [NUM_FLT-1:0][3:0] fltCnt;
      logic [NUM_FLT-1:0][15:0] fltRes;
      logic extSync1;
      logic extSync2;
      logic extPrev;
      core_req_t req;
      result_fwd_t fwd;
      logic [3:0] cmpHit;
      logic [3:0] fltHit;
      logic [31:0] rdata;
      logic rdErr;
   } state_t;

   state_t stateReg;
   state_t stateNext;
   logic [31:0] srcVec;
   logic [NUM_CH-1:0] trigHit;

   // sign or plain format at the configured width
   function automatic logic [15:0] formatSample(input logic [11:0] raw, input logic [1:0] res,
                                                input logic sgn);
      logic [15:0] mid;
      mid = 16'h0020 << (2 * res);
      formatSample = sgn ? (16'({4'h0, raw}) - mid) : 16'({4'h0, raw});
   endfunction

   // ==========================================================
   // trigger source vector, one bit per selector code
   always_comb begin
      srcVec = 32'h0;
      // RULE3 software triggers
      srcVec[SRC_SW_COMMON] = stateReg.swPulse;
      srcVec[SRC_SW_LEVEL] = stateReg.levelSw;
      // RULE9 generator pairs
      srcVec[SRC_SEC_PWM_LO +: 8] = {secPwmTrig2[3], secPwmTrig1[3], secPwmTrig2[2], secPwmTrig1[2],
                                     secPwmTrig2[1], secPwmTrig1[1], secPwmTrig2[1], secPwmTrig1[0]};
      // RULE8 upper generators
      srcVec[SRC_SEC_PWM_HI +: 4] = secPwmTrig1[7:4];
      // RULE7 capture unit events
      srcVec[SRC_CCP_BASE +: 4] = ccpEvent;
      // RULE6 primary generators
      srcVec[SRC_PRI_PWM1_T2] = priPwm1Trig2;
      srcVec[SRC_PRI_PWM3_T2] = priPwm3Trig2;
      // RULE5 generator and logic cells
      srcVec[SRC_PRI_CELL] = priClcTrig;
      srcVec[SRC_SEC_CELL] = secClcTrig;
      srcVec[SRC_PRI_GEN] = priGenTrig;
      // RULE4 external pin edge
      srcVec[SRC_EXT_PIN] = stateReg.extSync2 & ~stateReg.extPrev;
   end

   // per-input selection, reserved codes hold zero
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : gSel
         // RULE1 RULE2 RULE18 own selector
         assign trigHit[gi] = srcVec[stateReg.trigSel[gi]];
      end
   endgenerate

   // ==========================================================
   // next state
   always_comb begin
      logic [9:0] idx;
      logic wr;
      logic rd;
      logic [15:0] val;
      logic [11:0] raw;
      logic [NUM_CH-1:0] clrReady;
      logic hit;
      idx = apbReq.paddr[11:2];
      wr = apbReq.psel & apbReq.penable & apbReq.pwrite;
      rd = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
      val = 16'h0;
      raw = coreRsp.data;
      clrReady = '0;
      hit = 1'b0;
      stateNext = stateReg;
      stateNext.swPulse = 1'b0;
      stateNext.req.start = 1'b0;
      stateNext.fwd.valid = 1'b0;
      stateNext.cmpHit = 4'h0;
      stateNext.fltHit = 4'h0;
      stateNext.extSync1 = extTrigPin;
      stateNext.extSync2 = stateReg.extSync1;
      stateNext.extPrev = stateReg.extSync2;

      // register writes
      if (wr) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx == 10'(TRIG_SEL_BASE[11:2] + i)) begin
               stateNext.trigSel[i] = apbReq.pwdata[4:0];
               // RULE11 per-input format
               stateNext.signedFmt[i] = apbReq.pwdata[SEL_SIGNED_BIT];
            end
         end
         if (idx == CTRL_OFS[11:2]) begin
            // RULE17 resolution select
            stateNext.resolution = apbReq.pwdata[1:0];
            stateNext.levelSw = apbReq.pwdata[CTRL_LEVEL_BIT];
            stateNext.swPulse = apbReq.pwdata[CTRL_SWTRIG_BIT];
         end
         for (int k = 0; k < NUM_CMP; k++) begin
            if (idx == 10'(CMP_BASE[11:2] + k)) begin
               stateNext.cmpCfg[k] = apbReq.pwdata;
            end
            if (idx == 10'(FLT_CFG_BASE[11:2] + k)) begin
               stateNext.fltCfg[k] = apbReq.pwdata[8:0];
            end
         end
      end

      // read data is prepared in the setup cycle
      stateNext.rdata = 32'h0;
      stateNext.rdErr = 1'b0;
      if (apbReq.psel & ~apbReq.penable) begin
         stateNext.rdErr = 1'b1;
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx == 10'(TRIG_SEL_BASE[11:2] + i)) begin
               stateNext.rdata = {23'h0, stateReg.signedFmt[i], 3'h0, stateReg.trigSel[i]};
               stateNext.rdErr = 1'b0;
            end
            if (idx == 10'(RESULT_BASE[11:2] + i)) begin
               stateNext.rdata = {16'h0, stateReg.result[i]};
               stateNext.rdErr = 1'b0;
               clrReady[i] = rd;
            end
         end
         for (int k = 0; k < NUM_CMP; k++) begin
            if (idx == 10'(CMP_BASE[11:2] + k)) begin
               stateNext.rdata = stateReg.cmpCfg[k];
               stateNext.rdErr = 1'b0;
            end
            if (idx == 10'(FLT_CFG_BASE[11:2] + k)) begin
               stateNext.rdata = {23'h0, stateReg.fltCfg[k]};
               stateNext.rdErr = 1'b0;
            end
            if (idx == 10'(FLT_RES_BASE[11:2] + k)) begin
               stateNext.rdata = {16'h0, stateReg.fltRes[k]};
               stateNext.rdErr = 1'b0;
            end
         end
         if (idx == CTRL_OFS[11:2]) begin
            stateNext.rdata = {29'h0, stateReg.levelSw, stateReg.resolution};
            stateNext.rdErr = 1'b0;
         end
         if (idx == PEND_OFS[11:2]) begin
            stateNext.rdata = {12'h0, stateReg.pending};
            stateNext.rdErr = 1'b0;
         end
         if (idx == READY_OFS[11:2]) begin
            stateNext.rdata = {12'h0, stateReg.ready};
            stateNext.rdErr = 1'b0;
         end
      end

      // RULE19 queue requests, set beats service clear
      stateNext.pending = stateReg.pending | trigHit;
      stateNext.ready = stateReg.ready & ~clrReady;

      // RULE14 one shared core
      case (stateReg.coreState)
         CORE_IDLE: begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
               if (stateReg.pending[i]) begin
                  stateNext.curCh = 5'(i);
               end
            end
            if (|stateReg.pending) begin
               stateNext.pending[stateNext.curCh] = trigHit[stateNext.curCh];
               // RULE13 core gets format and input
               stateNext.req.start = 1'b1;
               stateNext.req.channel = stateNext.curCh;
               stateNext.req.resolution = stateReg.resolution;
               stateNext.req.signedFmt = stateReg.signedFmt[stateNext.curCh];
               stateNext.coreState = CORE_BUSY;
            end
         end
         CORE_BUSY: begin
            if (coreRsp.done) begin
               val = formatSample(raw, stateReg.req.resolution, stateReg.req.signedFmt);
               // RULE10 RULE12 store and forward
               stateNext.result[stateReg.curCh] = val;
               stateNext.ready[stateReg.curCh] = 1'b1;
               stateNext.fwd.valid = 1'b1;
               stateNext.fwd.channel = stateReg.curCh;
               stateNext.fwd.data = val;
               // RULE15 comparators on raw sample
               for (int k = 0; k < NUM_CMP; k++) begin
                  case (stateReg.cmpCfg[k][CFG_MODE_LSB +: 2])
                     CMP_BELOW: hit = raw < stateReg.cmpCfg[k][CMP_THR_LSB +: 12];
                     CMP_AT_ABOVE: hit = raw >= stateReg.cmpCfg[k][CMP_THR_LSB +: 12];
                     CMP_EQUAL: hit = raw == stateReg.cmpCfg[k][CMP_THR_LSB +: 12];
                     default: hit = raw != stateReg.cmpCfg[k][CMP_THR_LSB +: 12];
                  endcase
                  stateNext.cmpHit[k] = hit & stateReg.cmpCfg[k][CFG_EN_BIT]
                                        & (stateReg.cmpCfg[k][4:0] == stateReg.curCh);
               end
               // RULE16 sixteen-sample accumulation
               for (int k = 0; k < NUM_FLT; k++) begin
                  if (stateReg.fltCfg[k][CFG_EN_BIT] & (stateReg.fltCfg[k][4:0] == stateReg.curCh)) begin
                     if (stateReg.fltCnt[k] == FLT_LAST) begin
                        stateNext.fltRes[k] = (stateReg.fltSum[k] + 16'(raw)) >> FLT_SHIFT;
                        stateNext.fltHit[k] = 1'b1;
                        stateNext.fltSum[k] = 16'h0;
                        stateNext.fltCnt[k] = 4'h0;
                     end else begin
                        stateNext.fltSum[k] = stateReg.fltSum[k] + 16'(raw);
                        stateNext.fltCnt[k] = stateReg.fltCnt[k] + 4'h1;
                     end
                  end
               end
               stateNext.coreState = CORE_IDLE;
            end
         end
         default: begin
            stateNext.coreState = CORE_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stateReg <= '0;
         stateReg.coreState <= CORE_IDLE;
         stateReg.resolution <= RES_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   // ==========================================================
   // outputs
   assign pready = 1'b1; // zero wait states
   assign prdata = stateReg.rdata;
   assign pslverr = stateReg.rdErr;
   assign coreReq = stateReg.req;
   assign resultFwd = stateReg.fwd;
   assign cmpEvent = stateReg.cmpHit;
   assign fltDone = stateReg.fltHit;
endmodule
`default_nettype wire

//--- conv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
   import adc_trig_pkg::*;
#(
   parameter int LAT = 3
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire core_req_t coreReq,
   output var core_rsp_t coreRsp,
   input wire logic [11:0] sample
);
   logic [3:0] cnt;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt <= '0;
         coreRsp <= '0;
      end else begin
         coreRsp.done <= 1'b0;
         coreRsp.data <= ~coreRsp.data; // not held outside done
         if (coreReq.start) cnt <= 4'(LAT);
         else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               coreRsp.done <= 1'b1;
               coreRsp.data <= sample & 12'((13'h1 << (6 + 2 * coreReq.resolution)) - 13'h1);
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
   cmpCount++; \
   if ((g) !== (e)) begin \
      numErrors++; \
      $display("ERROR %s exp %h got %h", n, e, g); \
   end \
end
module tb;
   import adc_trig_pkg::*;
   typedef struct packed {logic [4:0] ch; logic [15:0] d; logic [3:0] cm; logic [3:0] fd;} exp_t;
   logic core_clk = 0, rst_n = 0, extPin = 0, sgn = 0, er;
   logic [15:0] fltAcc = '0, fltExp = '0;
   logic [19:0] rdyExp = '0;
   logic [20:0] src = '0;
   logic [11:0] sample = '0;
   apb_req_t apbReq = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr;
   core_req_t coreReq;
   core_rsp_t coreRsp;
   result_fwd_t resultFwd;
   logic [3:0] cmpEvent, fltDone;
   int numErrors = 0, cmpCount = 0, seed = 97478, n, c, ch, fltN = 0;
   exp_t q[$];
   exp_t m;
   always #5 core_clk = ~core_clk;
   adc_trigger_and_result_control uut (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extTrigPin(extPin), .priGenTrig(src[20]), .secClcTrig(src[19]),
      .priClcTrig(src[18]), .priPwm3Trig2(src[17]), .priPwm1Trig2(src[16]), .ccpEvent(src[15:12]),
      .secPwmTrig1(src[11:4]), .secPwmTrig2(src[3:0]), .coreReq(coreReq), .coreRsp(coreRsp),
      .resultFwd(resultFwd), .cmpEvent(cmpEvent), .fltDone(fltDone));
   conv_core_model core (.core_clk(core_clk), .rst_n(rst_n), .coreReq(coreReq), .coreRsp(coreRsp), .sample(sample));
   task giveVerdict;
      $display("checks %0d errors %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one APB transfer, read data taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk) apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk) apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (n >= 20) begin
         numErrors++;
         giveVerdict;
      end
   endtask
   task automatic chkRd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, '0);
      `CHK("prdata", x, rd)
      `CHK("pslverr", xe, er)
   endtask
   // note the result of one conversion of the current sample
   task automatic note(input int k, input logic [1:0] r, input logic sg);
      logic [15:0] raw;
      exp_t e;
      raw = 16'(sample) & ((16'h1 << (6 + 2 * r)) - 16'h1);
      e.ch = 5'(k);
      e.d = sg ? raw - (16'h1 << (5 + 2 * r)) : raw;
      e.cm = (k == 4) ? {raw != 16'h800, raw == 16'h800, raw >= 16'h800, raw < 16'h800} : 4'h0;
      e.fd = 4'h0;
      rdyExp[k] = 1'b1;
      // filter 0 sums sixteen raw samples of input 4
      if (k == 4) begin
         fltAcc = fltAcc + raw;
         fltN++;
      end
      if (fltN == 16) begin
         e.fd = 4'h1;
         fltExp = fltAcc >> FLT_SHIFT;
         fltAcc = 16'h0;
         fltN = 0;
      end
      q.push_back(e);
   endtask
   task automatic drain;
      n = 0;
      while (q.size() != 0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 200) begin
         numErrors++;
         giveVerdict;
      end
      repeat (12) @(posedge core_clk);
   endtask
   function automatic logic [20:0] srcOf(input int k);
      int b;
      b = -1;
      if (k >= 4 && k <= 11) b = k[0] ? ((k == 5) ? 1 : (k - 5) / 2) : k / 2 + 2;
      if (k >= 12 && k <= 15) b = k - 4;
      if (k >= 20 && k <= 25) b = k - 8;
      if (k >= 28 && k <= 30) b = k - 10;
      return (b < 0) ? 21'h0 : 21'h1 << b;
   endfunction
   // result monitor
   always @(posedge core_clk) begin
      if (resultFwd.valid === 1'b1) begin
         if (q.size() != 0) begin
            m = q.pop_front();
            `CHK("channel", m.ch, resultFwd.channel)
            `CHK("data", m.d, resultFwd.data)
            `CHK("cmpEvent", m.cm, cmpEvent)
            `CHK("fltDone", m.fd, fltDone)
         end else `CHK("stray", 1'b0, 1'b1)
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      chkRd(CTRL_OFS, 32'h3, 1'b0);
      chkRd(TRIG_SEL_BASE + 12'h04c, 32'h0, 1'b0);
      chkRd(12'h0f0, 32'h0, 1'b1);
      for (c = 0; c < 4; c++) apb(1'b1, CMP_BASE + 12'(4 * c), 32'h08000104 | (32'(c) << 9));
      apb(1'b1, FLT_CFG_BASE, 32'h104);
      // every code on a random input, other sources first
      for (c = 0; c < 32; c++) begin
         ch = ($random(seed) & 32'h7fff) % 20;
         sample = 12'($random(seed));
         sgn = 1'($random(seed));
         apb(1'b1, TRIG_SEL_BASE + 12'(4 * ch), (32'(sgn) << 8) | 32'(c));
         @(posedge core_clk) src <= ~srcOf(c);
         @(posedge core_clk) src <= '0;
         repeat (8) @(posedge core_clk);
         if (srcOf(c) != 0 || c == 1 || c == 2 || c == 31) note(ch, 2'd3, sgn);
         // level trigger held three cycles re-queues exactly once
         if (c == 2) note(ch, 2'd3, sgn);
         if (srcOf(c) != 0) @(posedge core_clk) src <= srcOf(c);
         @(posedge core_clk) src <= '0;
         if (c == 1) apb(1'b1, CTRL_OFS, 32'hb);
         if (c == 2) begin
            apb(1'b1, CTRL_OFS, 32'h7);
            apb(1'b1, CTRL_OFS, 32'h3);
         end
         if (c == 31) begin
            extPin <= 1'b1;
            repeat (4) @(posedge core_clk);
            extPin <= 1'b0;
         end
         drain;
         apb(1'b1, TRIG_SEL_BASE + 12'(4 * ch), 32'h0);
      end
      // two inputs on one source, lower input served first
      apb(1'b1, TRIG_SEL_BASE + 12'h01c, 32'h1e);
      apb(1'b1, TRIG_SEL_BASE + 12'h008, 32'h11e);
      sample = 12'h9a5;
      note(2, 2'd3, 1'b1);
      note(7, 2'd3, 1'b0);
      @(posedge core_clk) src <= 21'h100000;
      @(posedge core_clk) src <= '0;
      drain;
      chkRd(RESULT_BASE + 12'h01c, 32'h9a5, 1'b0);
      chkRd(RESULT_BASE + 12'h008, 32'h1a5, 1'b0);
      chkRd(PEND_OFS, 32'h0, 1'b0);
      // reading a result clears that input's ready bit
      rdyExp[2] = 1'b0;
      rdyExp[7] = 1'b0;
      chkRd(READY_OFS, {12'h0, rdyExp}, 1'b0);
      // every resolution and format on the compared input
      for (c = 0; c < 20; c++) begin
         sample = (c == 7) ? 12'h800 : 12'($random(seed));
         apb(1'b1, TRIG_SEL_BASE + 12'h010, {23'h0, c[2], 8'h01});
         note(4, 2'(c), c[2]);
         apb(1'b1, CTRL_OFS, 32'h8 | 32'(c[1:0]));
         drain;
      end
      chkRd(FLT_RES_BASE, {16'h0, fltExp}, 1'b0);
      giveVerdict;
   end
endmodule
`default_nettype wire
